// *** inc/nvm_shadow_cfg.svh ***
// Summary of operation
// - bit 7 clamps fourth buck code to 0x1c
// - bit 6 forces third linear into passthrough
// - three two-bit start ranks, rank0 to rank3
// - fourth buck default: 1.15/1.2/1.8/3.3 V
// - third buck default: 1.2/1.8/3.0/3.3 V
// - second buck default: 1.1/1.2/1.35/1.5 V
// - first buck default: 1.1/1.15/1.2/1.5 V
// - boost overvoltage switches general switch off
// - third linear default, code 11 halves buck
// - second linear default: 1.8/2.5/2.9/3.3 V
// - first linear default, same code set
// - sixth linear default; bits 7:4 reserved
// - fifth linear default: 1.8/2.5/2.9/3.3 V
// - seven-bit bus address, applied at once
// - all five registers read and write
`ifndef NVM_SHADOW_CFG_SVH
`define NVM_SHADOW_CFG_SVH
`define OFS_RANK_OPT     8'hfb
`define OFS_BUCK_LEVEL   8'hfc
`define OFS_LIN_LEVEL_1  8'hfd
`define OFS_LIN_LEVEL_2  8'hfe
`define OFS_BUS_ADDR     8'hff
`define POS_BUCK4_LIMIT  7
`define POS_LIN3_PASS    6
`define POS_SW_OFF_OVP   7
`define BUCK4_LIMIT_CODE 6'h1c
`define LIN3_TRACK_SEL   2'h3
`define RST_SHADOW       8'h00
`endif

// *** inc/nvm_shadow_pkg.sv ***
package nvm_shadow_pkg;
  // decoded start ranks for the sequencer
  typedef struct packed {
    logic [1:0] memory_reference_start_rank;
    logic [1:0] sixth_linear_start_rank;
    logic [1:0] fifth_linear_start_rank;
  } rank_set_t;
  // default level selections, two bits each
  typedef struct packed {
    logic [1:0] fourth_buck_default_level;
    logic [1:0] third_buck_default_level;
    logic [1:0] second_buck_default_level;
    logic [1:0] first_buck_default_level;
    logic [1:0] third_linear_default_level;
    logic [1:0] second_linear_default_level;
    logic [1:0] first_linear_default_level;
    logic [1:0] sixth_linear_default_level;
    logic [1:0] fifth_linear_default_level;
  } level_set_t;
endpackage

// *** rtl/nvm_shadow_config_regs.sv ***
`timescale 1ns/1ps
`include "nvm_shadow_cfg.svh"
module nvm_shadow_config_regs (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic [39:0]               nvm_image,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  output logic                           reg_hit,
  output logic                           shadow_loaded,
  input  wire logic [5:0]                fourth_buck_voltage_code_req,
  output logic      [5:0]                fourth_buck_voltage_code,
  input  wire logic [5:0]                second_buck_voltage_code,
  output logic                           third_linear_tracks_buck,
  output logic      [5:0]                third_linear_track_code,
  output logic                           third_linear_forced_passthrough,
  output nvm_shadow_pkg::rank_set_t      ranks,
  output nvm_shadow_pkg::level_set_t     levels,
  input  wire logic                      boost_overvoltage,
  output logic                           general_power_switch_allow,
  output logic      [6:0]                bus_slave_address
);
  // shadow bank, index 0 is 0xfb through index 4 at 0xff
  logic [7:0] shadow_reg [5];
  logic [7:0] shadow_next [5];
  logic       loaded_reg;   // high once image copy is done
  logic       loaded_next;
  logic       ovp_off_reg;  // latched switch-off after overvoltage
  logic       ovp_off_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       hit_reg;
  logic       hit_next;
  logic [2:0] sel;          // decoded register index
  logic       sel_ok;

  // address decode, unmapped offsets miss
  always_comb begin
    sel    = 3'h0;
    sel_ok = 1'b1;
    if (reg_addr == `OFS_RANK_OPT) begin
      sel = 3'h0;
    end else if (reg_addr == `OFS_BUCK_LEVEL) begin
      sel = 3'h1;
    end else if (reg_addr == `OFS_LIN_LEVEL_1) begin
      sel = 3'h2;
    end else if (reg_addr == `OFS_LIN_LEVEL_2) begin
      sel = 3'h3;
    end else if (reg_addr == `OFS_BUS_ADDR) begin
      sel = 3'h4;
    end else begin
      sel_ok = 1'b0;
    end
  end

  // next shadow contents: image copy first, then host writes
  always_comb begin
    loaded_next = 1'b1;
    for (int i = 0; i < 5; i++) begin
      shadow_next[i] = shadow_reg[i];
    end
    if (!loaded_reg) begin
      // first clock after reset copies the non-volatile image
      for (int i = 0; i < 5; i++) begin
        shadow_next[i] = nvm_image[i*8 +: 8];
      end
    end else if (reg_wr && sel_ok) begin
      // every register is writable, reserved bits are kept too
      shadow_next[sel] = reg_wdata;
    end
  end

  // read data is registered, reserved bits read back as stored
  always_comb begin
    rdata_next = rdata_reg;
    hit_next   = 1'b0;
    if (reg_rd) begin
      hit_next   = sel_ok;
      rdata_next = sel_ok ? shadow_reg[sel] : 8'h00;
    end
  end

  // switch-off latch: set by overvoltage while enabled, cleared
  // when the option is turned off so the switch may run again
  always_comb begin
    ovp_off_next = ovp_off_reg;
    if (!shadow_reg[2][`POS_SW_OFF_OVP]) begin
      ovp_off_next = 1'b0;
    end else if (boost_overvoltage && loaded_reg) begin
      ovp_off_next = 1'b1;
    end
  end

  // registers only hold values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 5; i++) begin
        shadow_reg[i] <= `RST_SHADOW;
      end
      loaded_reg  <= 1'b0;
      ovp_off_reg <= 1'b0;
      rdata_reg   <= 8'h00;
      hit_reg     <= 1'b0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        shadow_reg[i] <= shadow_next[i];
      end
      loaded_reg  <= loaded_next;
      ovp_off_reg <= ovp_off_next;
      rdata_reg   <= rdata_next;
      hit_reg     <= hit_next;
    end
  end

  assign reg_rdata     = rdata_reg;
  assign reg_hit       = hit_reg;
  // sequencer must wait for this before using ranks or levels
  assign shadow_loaded = loaded_reg;

  // clamp the requested fourth buck code when the limit is on
  always_comb begin
    fourth_buck_voltage_code = fourth_buck_voltage_code_req;
    if (shadow_reg[0][`POS_BUCK4_LIMIT] &&
        fourth_buck_voltage_code_req > `BUCK4_LIMIT_CODE) begin
      fourth_buck_voltage_code = `BUCK4_LIMIT_CODE;
    end
  end

  assign third_linear_forced_passthrough =
    shadow_reg[0][`POS_LIN3_PASS];
  assign ranks.memory_reference_start_rank = shadow_reg[0][5:4];
  assign ranks.sixth_linear_start_rank     = shadow_reg[0][3:2];
  assign ranks.fifth_linear_start_rank     = shadow_reg[0][1:0];

  assign levels.fourth_buck_default_level  = shadow_reg[1][7:6];
  assign levels.third_buck_default_level   = shadow_reg[1][5:4];
  assign levels.second_buck_default_level  = shadow_reg[1][3:2];
  assign levels.first_buck_default_level   = shadow_reg[1][1:0];
  assign levels.third_linear_default_level = shadow_reg[2][5:4];
  assign levels.second_linear_default_level = shadow_reg[2][3:2];
  assign levels.first_linear_default_level = shadow_reg[2][1:0];
  assign levels.sixth_linear_default_level = shadow_reg[3][3:2];
  assign levels.fifth_linear_default_level = shadow_reg[3][1:0];

  // code 11 makes the third linear follow half the second buck
  assign third_linear_tracks_buck =
    (shadow_reg[2][5:4] == `LIN3_TRACK_SEL);
  assign third_linear_track_code =
    {1'b0, second_buck_voltage_code[5:1]};

  // held off once an enabled overvoltage has been seen
  assign general_power_switch_allow = !ovp_off_reg;

  // address follows the register with no reload; the host must
  // address the device at the new value from the next access
  assign bus_slave_address = shadow_reg[4][6:0];
endmodule

// *** dv/nvm_shadow_chk.sv ***
`timescale 1ns/1ps
// checker sees only the top ports, so it ties outputs to bus writes
module nvm_shadow_chk (
  input wire logic        clk, rst_b, reg_wr, reg_rd, reg_hit,
  input wire logic        shadow_loaded, third_linear_forced_passthrough,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata,
  input wire logic [5:0]  fourth_buck_voltage_code_req,
  input wire logic [5:0]  fourth_buck_voltage_code,
  input wire logic [5:0]  second_buck_voltage_code, third_linear_track_code,
  input wire logic [6:0]  bus_slave_address,
  input wire logic [39:0] nvm_image,
  input nvm_shadow_pkg::rank_set_t  ranks,
  input nvm_shadow_pkg::level_set_t levels
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic wt = reg_wr && shadow_loaded; // writes before load are dropped
  wire logic rt = reg_rd && shadow_loaded;
  addr_apply_a: assert property (wt && reg_addr == 8'hff |=>
    bus_slave_address == $past(reg_wdata[6:0])) else $error("addr");
  miss_read_a: assert property (rt && reg_addr < 8'hfb |=>
    reg_rdata == 8'h00 && !reg_hit) else $error("miss");
  hit_pulse_a: assert property (rt && reg_addr >= 8'hfb |=>
    reg_hit ##1 (!reg_hit || $past(reg_rd))) else $error("hit");
  buck_clamp_a: assert property (fourth_buck_voltage_code ==
    fourth_buck_voltage_code_req || (fourth_buck_voltage_code == 6'h1c
    && fourth_buck_voltage_code_req > 6'h1c)) else $error("clamp");
  track_half_a: assert property (third_linear_track_code ==
    {1'b0, second_buck_voltage_code[5:1]}) else $error("track");
  bypass_set_a: assert property (wt && reg_addr == 8'hfb |=>
    third_linear_forced_passthrough == $past(reg_wdata[6]))
    else $error("bypass");
  rank_set_a: assert property (wt && reg_addr == 8'hfb |=>
    ranks == $past(reg_wdata[5:0])) else $error("rank");
  buck_level_a: assert property (wt && reg_addr == 8'hfc |=>
    levels[17:10] == $past(reg_wdata)) else $error("level");
  image_load_a: assert property ($rose(shadow_loaded) |->
    ranks == $past(nvm_image[5:0])) else $error("load");
  cover property (wt && reg_addr == 8'hfd);
  cover property (fourth_buck_voltage_code != fourth_buck_voltage_code_req);
  cover property ($rose(reg_hit));
endmodule
bind nvm_shadow_config_regs nvm_shadow_chk i_nvm_shadow_chk (.*);

// *** dv/host_model.sv ***
`timescale 1ns/1ps
// host side of the strobe bus; releases lines to inverted values
module host_model (
  input  wire logic       clk, reg_hit,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr, reg_rd,
  output logic [7:0]      reg_addr, reg_wdata
);
  logic [6:0] dev_addr = 7'h00; // address the host now talks to
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
    if (a == 8'hff) dev_addr = d[6:0];
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) {reg_rd, reg_addr} <= {1'b0, ~a};
    #1 {d, h} = {reg_rdata, reg_hit};
  endtask
endmodule

// *** dv/nvm_shadow_config_regs_tb.sv ***
`timescale 1ns/1ps
module nvm_shadow_config_regs_tb;
  logic clk = 0, rst_b = 0, boost_overvoltage = 0, h, pass, allow, trk_on;
  logic reg_wr, reg_rd, reg_hit, shadow_loaded;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] req = 6'h00, sb = 6'h00, b4, trk;
  logic [6:0] sla;
  logic [39:0] nvm_image = 40'h4a_a5_96_3c_e7; // arbitrary variant image
  nvm_shadow_pkg::rank_set_t ranks;
  nvm_shadow_pkg::level_set_t levels;
  int num_errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  nvm_shadow_config_regs i_nvm_shadow_config_regs (.clk, .rst_b,
    .nvm_image, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_hit, .shadow_loaded, .fourth_buck_voltage_code_req(req),
    .fourth_buck_voltage_code(b4), .second_buck_voltage_code(sb),
    .third_linear_tracks_buck(trk_on), .third_linear_track_code(trk),
    .third_linear_forced_passthrough(pass), .ranks, .levels,
    .boost_overvoltage, .general_power_switch_allow(allow),
    .bus_slave_address(sla));
  host_model i_host_model (.clk, .reg_hit, .reg_rdata, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata);
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // every shadow must hold its image byte before anything is written
  task automatic t_load;
    for (int i = 0; i < 5; i++) begin
      i_host_model.rd(8'hfb + i[7:0], d, h);
      chk(d, nvm_image[8*i +: 8]);
      chk({7'h0, h}, 8'h01);
    end
    chk({1'b0, sla}, {1'b0, nvm_image[38:32]});
    $display("test load done");
  endtask
  // write all five, read back, then an unmapped read must miss
  task automatic t_rw;
    logic [7:0] v [5] = '{8'h12, 8'h1b, 8'h6c, 8'hf9, 8'hd5};
    for (int i = 0; i < 5; i++) i_host_model.wr(8'hfb + i[7:0], v[i]);
    for (int i = 0; i < 5; i++) begin
      i_host_model.rd(8'hfb + i[7:0], d, h);
      chk(d, v[i]);
    end
    chk({2'h0, ranks}, 8'h12);
    chk(levels[17:10], 8'h1b);
    chk({2'h0, levels[9:4]}, 8'h2c);
    chk({4'h0, levels[3:0]}, 8'h09);
    chk({1'b0, sla}, 8'h55);
    chk({1'b0, i_host_model.dev_addr}, 8'h55);
    i_host_model.rd(8'hfa, d, h);
    chk(d, 8'h00);
    chk({7'h0, h}, 8'h00);
    $display("test rw done");
  endtask
  // clamp, passthrough, overvoltage switch-off and tracking
  task automatic t_opt;
    i_host_model.wr(8'hfb, 8'hc0);
    @(posedge clk) {req, sb, boost_overvoltage} <= {6'h3f, 6'h2b, 1'b1};
    @(posedge clk) #1;
    chk({2'h0, b4}, 8'h1c);
    chk({6'h0, pass, allow}, 8'h03);
    chk({2'h0, trk}, 8'h15);
    i_host_model.wr(8'hfd, 8'hb0);
    repeat (2) @(posedge clk);
    #1 chk({6'h0, allow, trk_on}, 8'h01);
    i_host_model.wr(8'hfb, 8'h00);
    #1 chk({1'b0, pass, b4}, 8'h3f);
    $display("test options done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_load;
    t_rw;
    t_opt;
    wrap_up;
  end
  initial begin
    #100us;
    num_errors++;
    wrap_up;
  end
endmodule
